// >>> logic/ecc_ctrl_regs.sv
// Control register bank of the dual echo canceller, reached over the serial microport
`timescale 1ns/1ns
`default_nettype none
module ecc_ctrl_regs
  import ecc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        ce,
  // Serial microport
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe_n,
  // Port formats
  input  wire logic        send_linear16,
  input  wire logic        recv_linear16,
  // Sample path
  input  wire logic [15:0] send_in,
  input  wire logic [15:0] recv_in,
  input  wire logic [15:0] send_proc,
  input  wire logic [15:0] recv_proc,
  output logic [15:0]      send_in_sh,
  output logic [15:0]      recv_in_sh,
  output logic [15:0]      send_out,
  output logic [15:0]      recv_out,
  // Main controls
  output logic             init_busy,
  output logic             howl_detect_disable,
  output logic             auto_gain_disable,
  output logic             narrowband_detect_disable,
  output logic             path_bypass,
  output logic             send_mute,
  output logic             recv_mute,
  output logic             linear_two_bit_shift,
  // Line canceller controls
  output logic             line_estimate_subtract_skip,
  output logic             line_coefficient_update_freeze,
  output logic             line_coefficient_clear,
  output logic             line_offset_null_skip,
  output logic             line_comfort_noise_disable,
  output logic             line_residual_suppressor_disable,
  output logic             line_step_speed_control_disable,
  // Acoustic canceller controls
  output logic             acou_estimate_subtract_skip,
  output logic             acou_coefficient_update_freeze,
  output logic             acou_coefficient_clear,
  output logic             acou_offset_null_skip,
  output logic             acou_comfort_noise_disable,
  output logic             acou_residual_suppressor_disable,
  output logic             acou_step_speed_control_disable,
  output logic             acou_weighting_disable
);
  // ****************************************************
  // Declarations
  // ****************************************************
  logic [7:0] main_q;
  logic [7:0] line_q;
  logic [7:0] acou_q;
  ecc_init_t  init_q;
  logic [3:0] icnt_q;
  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  logic       wr_stb;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic       shift_act;
  logic       wr_main;
  logic       wr_line;
  logic       wr_acou;
  logic       init_start;

  // Register select: 0 main, 1 line, 2 acoustic, 3 unmapped
  function automatic logic [1:0] reg_sel(input logic [6:0] a);
    unique case (a)
      ECC_MAIN_ADDR: reg_sel = 2'h0;
      ECC_LINE_ADDR: reg_sel = 2'h1;
      ECC_ACOU_ADDR: reg_sel = 2'h2;
      default:       reg_sel = 2'h3;
    endcase
  endfunction

  // ****************************************************
  // Microport
  // ****************************************************
  ecc_uport ecc_uport_inst (
    .mclk     (mclk),
    .rstn     (rstn),
    .ce       (ce),
    .sclk     (sclk),
    .cs_n     (cs_n),
    .sdi      (sdi),
    .sdo      (sdo),
    .sdo_oe_n (sdo_oe_n),
    .rd_addr  (rd_addr),
    .rd_data  (rd_data),
    .wr_stb   (wr_stb),
    .wr_addr  (wr_addr),
    .wr_data  (wr_data)
  );

  // Writes decode only while idle; during init they would be overwritten anyway
  assign wr_main    = wr_stb & (init_q == ECC_IDLE) & (reg_sel(wr_addr) == 2'h0);
  assign wr_line    = wr_stb & (init_q == ECC_IDLE) & (reg_sel(wr_addr) == 2'h1);
  assign wr_acou    = wr_stb & (init_q == ECC_IDLE) & (reg_sel(wr_addr) == 2'h2);
  assign init_start = wr_main & wr_data[MAIN_INIT];

  // ****************************************************
  // Initialization sequencer
  // ****************************************************
  // Holds every register at default for a fixed stretch, then releases
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      init_q <= ECC_IDLE;
      icnt_q <= 4'h0;
    end else if (ce) begin
      unique case (init_q)
        ECC_IDLE: begin
          if (init_start) begin
            init_q <= ECC_CLEAR;
            icnt_q <= ECC_INIT_LOAD;
          end
        end
        ECC_CLEAR: begin
          if (icnt_q == 4'h0) begin
            init_q <= ECC_RELEASE;
          end else begin
            icnt_q <= icnt_q - 4'h1;
          end
        end
        ECC_RELEASE: begin
          init_q <= ECC_IDLE;
        end
        default: begin
          init_q <= ECC_IDLE;
        end
      endcase
    end
  end

  // ****************************************************
  // Control registers
  // ****************************************************
  // Main control; bit 0 is never stored, it reads back from the sequencer
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      main_q <= ECC_MAIN_RST;
    end else if (ce) begin
      if (init_q != ECC_IDLE || init_start) begin
        main_q <= ECC_MAIN_RST;
      end else if (wr_main) begin
        main_q <= {wr_data[7:1], 1'b0};
      end
    end
  end

  // Line canceller control
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      line_q <= ECC_LINE_RST;
    end else if (ce) begin
      if (init_q != ECC_IDLE || init_start) begin
        line_q <= ECC_LINE_RST;
      end else if (wr_line) begin
        line_q <= wr_data;
      end
    end
  end

  // Acoustic canceller control
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      acou_q <= ECC_ACOU_RST;
    end else if (ce) begin
      if (init_q != ECC_IDLE || init_start) begin
        acou_q <= ECC_ACOU_RST;
      end else if (wr_acou) begin
        acou_q <= wr_data;
      end
    end
  end

  // Read mux; unmapped addresses answer zero
  always_comb begin
    unique case (reg_sel(rd_addr))
      2'h0:    rd_data = {main_q[7:1], init_q != ECC_IDLE};
      2'h1:    rd_data = line_q;
      2'h2:    rd_data = acou_q;
      default: rd_data = ECC_UNMAPPED;
    endcase
  end

  // ****************************************************
  // Control outputs, straight from register bits except init busy and the gated shift
  // ****************************************************
  assign init_busy                 = init_q != ECC_IDLE;
  assign howl_detect_disable       = main_q[MAIN_HOWL];
  assign auto_gain_disable         = main_q[MAIN_GAIN];
  assign narrowband_detect_disable = main_q[MAIN_NBAND];
  assign path_bypass               = main_q[MAIN_BYPASS];
  assign send_mute                 = main_q[MAIN_MUTE_S];
  assign recv_mute                 = main_q[MAIN_MUTE_R];

  // Shift honoured only with permit and both ports linear
  assign shift_act = line_q[CC_TOP] & main_q[MAIN_SHPERM]
                   & send_linear16 & recv_linear16;
  assign linear_two_bit_shift = shift_act;

  // Line canceller acts on the receive path
  assign line_estimate_subtract_skip      = line_q[CC_SKIP];
  assign line_coefficient_update_freeze   = line_q[CC_FREEZE];
  assign line_coefficient_clear           = line_q[CC_CLEAR];
  assign line_offset_null_skip            = line_q[CC_OFFNULL];
  assign line_comfort_noise_disable       = line_q[CC_NOISE];
  assign line_residual_suppressor_disable = line_q[CC_SUPP];
  assign line_step_speed_control_disable  = line_q[CC_SPEED];

  // Acoustic canceller acts on the send path
  assign acou_estimate_subtract_skip      = acou_q[CC_SKIP];
  assign acou_coefficient_update_freeze   = acou_q[CC_FREEZE];
  assign acou_coefficient_clear           = acou_q[CC_CLEAR];
  assign acou_offset_null_skip            = acou_q[CC_OFFNULL];
  assign acou_comfort_noise_disable       = acou_q[CC_NOISE];
  assign acou_residual_suppressor_disable = acou_q[CC_SUPP];
  assign acou_step_speed_control_disable  = acou_q[CC_SPEED];
  assign acou_weighting_disable           = acou_q[CC_TOP];

  // ****************************************************
  // Sample scaling
  // ****************************************************
  ecc_lin_shift ecc_lin_shift_inst (
    .mclk       (mclk),
    .rstn       (rstn),
    .ce         (ce),
    .shift_en   (shift_act),
    .send_in    (send_in),
    .recv_in    (recv_in),
    .send_proc  (send_proc),
    .recv_proc  (recv_proc),
    .send_in_sh (send_in_sh),
    .recv_in_sh (recv_in_sh),
    .send_out   (send_out),
    .recv_out   (recv_out)
  );

  // ****************************************************
  // Checks
  // ****************************************************
  a_init_clears: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && init_q == ECC_IDLE && init_start) |=> (init_q == ECC_CLEAR)
      ##[1:40] (init_q == ECC_IDLE))
    else $error("init bit did not self-clear");

  a_init_defaults: assert property (@(posedge mclk) disable iff (!rstn)
    (init_q == ECC_RELEASE) |-> (main_q == ECC_MAIN_RST && line_q == ECC_LINE_RST
      && acou_q == ECC_ACOU_RST))
    else $error("registers not preset by init");

  a_init_poll: assert property (@(posedge mclk) disable iff (!rstn)
    (init_q != ECC_IDLE && reg_sel(rd_addr) == 2'h0) |-> rd_data[MAIN_INIT])
    else $error("init bit reads zero while busy");

  a_main_write: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && wr_main && !wr_data[MAIN_INIT]) |=>
      ({recv_mute, send_mute, path_bypass, narrowband_detect_disable,
        auto_gain_disable, howl_detect_disable} == $past(wr_data[6:1])))
    else $error("main control outputs do not follow write");

  a_line_write: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && wr_line) |=> (line_residual_suppressor_disable == $past(wr_data[CC_SUPP])
      && line_coefficient_clear == $past(wr_data[CC_CLEAR])))
    else $error("line control outputs do not follow write");

  a_acou_write: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && wr_acou) |=> (acou_weighting_disable == $past(wr_data[CC_TOP])
      && acou_estimate_subtract_skip == $past(wr_data[CC_SKIP])))
    else $error("acoustic control outputs do not follow write");

  a_shift_gate: assert property (@(posedge mclk) disable iff (!rstn)
    !(send_linear16 && recv_linear16 && main_q[MAIN_SHPERM]) |-> !linear_two_bit_shift)
    else $error("shift active without permit or linear ports");

  a_reset_zero: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(rstn) |-> (main_q == 8'h00 && line_q == 8'h00 && acou_q == 8'h00))
    else $error("registers not zero after reset");
endmodule // ecc_ctrl_regs
`default_nettype wire

// >>> logic/ecc_lin_shift.sv
// Two-bit scaling of linear samples on both paths
`timescale 1ns/1ns
`default_nettype none
module ecc_lin_shift
  import ecc_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        ce,
  // Control
  input  wire logic        shift_en,
  // Samples
  input  wire logic [15:0] send_in,
  input  wire logic [15:0] recv_in,
  input  wire logic [15:0] send_proc,
  input  wire logic [15:0] recv_proc,
  output logic [15:0]      send_in_sh,
  output logic [15:0]      recv_in_sh,
  output logic [15:0]      send_out,
  output logic [15:0]      recv_out
);
  // Inputs scaled down, outputs scaled up; one register stage
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      send_in_sh <= 16'h0000;
      recv_in_sh <= 16'h0000;
      send_out   <= 16'h0000;
      recv_out   <= 16'h0000;
    end else if (ce) begin
      send_in_sh <= shift_en ? ecc_asr2(send_in) : send_in;
      recv_in_sh <= shift_en ? ecc_asr2(recv_in) : recv_in;
      send_out   <= shift_en ? ecc_asl2(send_proc) : send_proc;
      recv_out   <= shift_en ? ecc_asl2(recv_proc) : recv_proc;
    end
  end

  a_shift_scale: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && shift_en) |=> (send_in_sh == ecc_asr2($past(send_in)))
      && (recv_out == ecc_asl2($past(recv_proc))))
    else $error("linear shift scaling wrong");
endmodule // ecc_lin_shift
`default_nettype wire

// >>> logic/ecc_pkg.sv
// Shared constants, types and helpers for the echo canceller control bank
`default_nettype none
package ecc_pkg;
  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [6:0] ECC_MAIN_ADDR = 7'h00;
  localparam logic [6:0] ECC_LINE_ADDR = 7'h01;
  localparam logic [6:0] ECC_ACOU_ADDR = 7'h21;
  localparam logic [7:0] ECC_MAIN_RST  = 8'h00;
  localparam logic [7:0] ECC_LINE_RST  = 8'h00;
  localparam logic [7:0] ECC_ACOU_RST  = 8'h00;
  localparam logic [7:0] ECC_UNMAPPED  = 8'h00;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int MAIN_INIT   = 0;
  localparam int MAIN_HOWL   = 1;
  localparam int MAIN_GAIN   = 2;
  localparam int MAIN_NBAND  = 3;
  localparam int MAIN_BYPASS = 4;
  localparam int MAIN_MUTE_S = 5;
  localparam int MAIN_MUTE_R = 6;
  localparam int MAIN_SHPERM = 7;
  localparam int CC_SKIP     = 0;
  localparam int CC_FREEZE   = 1;
  localparam int CC_CLEAR    = 2;
  localparam int CC_OFFNULL  = 3;
  localparam int CC_NOISE    = 4;
  localparam int CC_SUPP     = 5;
  localparam int CC_SPEED    = 6;
  localparam int CC_TOP      = 7;

  // ****************************************************
  // Serial frame and timing
  // ****************************************************
  localparam int          ECC_CMD_RD_BIT = 7;
  localparam logic [3:0]  ECC_CMD_LAST   = 4'h7;
  localparam logic [3:0]  ECC_FRAME_LAST = 4'hF;
  localparam int          ECC_MCLK_NS    = 40;
  localparam int          ECC_INIT_NS    = 320;
  localparam int          ECC_INIT_CYC   = (ECC_INIT_NS + ECC_MCLK_NS - 1) / ECC_MCLK_NS;
  localparam logic [3:0]  ECC_INIT_LOAD  = 4'(ECC_INIT_CYC - 1);

  // Initialization sequencer, Gray along IDLE -> CLEAR -> RELEASE
  typedef enum logic [1:0] {
    ECC_IDLE    = 2'b00,
    ECC_CLEAR   = 2'b01,
    ECC_RELEASE = 2'b11
  } ecc_init_t;

  // Arithmetic right shift by two, sign kept
  function automatic logic [15:0] ecc_asr2(input logic [15:0] v);
    ecc_asr2 = {v[15], v[15], v[15:2]};
  endfunction

  // Left shift by two, zero fill
  function automatic logic [15:0] ecc_asl2(input logic [15:0] v);
    ecc_asl2 = {v[13:0], 2'b00};
  endfunction
endpackage
`default_nettype wire

// >>> logic/ecc_uport.sv
// Serial microport slave: 8-bit command then 8-bit data, MSB first
`timescale 1ns/1ns
`default_nettype none
module ecc_uport
  import ecc_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       ce,
  // Microport pins
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       sdi,
  output logic            sdo,
  output logic            sdo_oe_n,
  // Register side
  output logic [6:0]      rd_addr,
  input  wire logic [7:0] rd_data,
  output logic            wr_stb,
  output logic [6:0]      wr_addr,
  output logic [7:0]      wr_data
);
  logic       sclk_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic       rd_q;
  logic       cmd_q;
  logic       load_q;
  logic       sdo_q;
  logic       rise;
  logic       fall;

  // Edges of the serial clock, sampled as a plain synchronous input
  assign rise = sclk & ~sclk_q & ~cs_n;
  assign fall = ~sclk & sclk_q & ~cs_n;

  // Bit counter and shift-in; chip select high aborts a frame
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sclk_q <= 1'b0;
      cnt_q  <= 4'h0;
      sh_q   <= 8'h00;
      cmd_q  <= 1'b0;
      rd_q   <= 1'b0;
      rd_addr <= 7'h00;
    end else if (ce) begin
      sclk_q <= sclk;
      if (cs_n) begin
        cnt_q <= 4'h0;
        cmd_q <= 1'b0;
      end else if (rise) begin
        cnt_q <= cnt_q + 4'h1;
        sh_q  <= {sh_q[6:0], sdi};
        if (cnt_q == ECC_CMD_LAST) begin
          cmd_q   <= 1'b1;
          rd_q    <= sh_q[ECC_CMD_RD_BIT - 1];
          rd_addr <= {sh_q[5:0], sdi};
        end
      end
    end
  end

  // Write strobe at the last data bit of a write frame
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wr_stb  <= 1'b0;
      wr_addr <= 7'h00;
      wr_data <= 8'h00;
    end else if (ce) begin
      wr_stb <= rise & cmd_q & ~rd_q & (cnt_q == ECC_FRAME_LAST);
      if (rise & cmd_q & (cnt_q == ECC_FRAME_LAST)) begin
        wr_addr <= rd_addr;
        wr_data <= {sh_q[6:0], sdi};
      end
    end
  end

  // Read data loads one cycle after the command, well before the next falling edge
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      load_q <= 1'b0;
      tx_q   <= 8'h00;
      sdo_q  <= 1'b0;
    end else if (ce) begin
      load_q <= rise & (cnt_q == ECC_CMD_LAST);
      if (load_q) begin
        tx_q <= rd_data;
      end else if (fall & cmd_q & rd_q) begin
        sdo_q <= tx_q[7];
        tx_q  <= {tx_q[6:0], 1'b0};
      end
    end
  end

  assign sdo      = sdo_q;
  assign sdo_oe_n = ~(~cs_n & cmd_q & rd_q);
endmodule // ecc_uport
`default_nettype wire

// >>> verif/ecc_ctrl_regs_test.sv
// Self-checking testbench of the echo canceller control register bank
`timescale 1ns/1ns
`default_nettype none
module ecc_ctrl_regs_test;
  logic mclk, rstn, ce, sclk, cs_n, sdi, sdo, sdo_oe_n, send_linear16, recv_linear16;
  logic [15:0] send_in, recv_in, send_proc, recv_proc;
  logic [15:0] send_in_sh, recv_in_sh, send_out, recv_out;
  logic init_busy, howl_detect_disable, auto_gain_disable, narrowband_detect_disable;
  logic path_bypass, send_mute, recv_mute, linear_two_bit_shift;
  logic line_estimate_subtract_skip, line_coefficient_update_freeze, line_coefficient_clear;
  logic line_offset_null_skip, line_comfort_noise_disable, line_residual_suppressor_disable;
  logic line_step_speed_control_disable, acou_estimate_subtract_skip, acou_coefficient_clear;
  logic acou_coefficient_update_freeze, acou_offset_null_skip, acou_comfort_noise_disable;
  logic acou_residual_suppressor_disable, acou_step_speed_control_disable;
  logic acou_weighting_disable, seen_busy, ok;
  logic [7:0] rd, mainv, linev, acouv;
  int fail_count, comparisons, cycles;

  ecc_ctrl_regs ecc_ctrl_regs_inst (.mclk, .rstn, .ce, .sclk, .cs_n, .sdi, .sdo, .sdo_oe_n,
    .send_linear16, .recv_linear16, .send_in, .recv_in, .send_proc, .recv_proc,
    .send_in_sh, .recv_in_sh, .send_out, .recv_out, .init_busy, .howl_detect_disable,
    .auto_gain_disable, .narrowband_detect_disable, .path_bypass, .send_mute, .recv_mute,
    .linear_two_bit_shift, .line_estimate_subtract_skip, .line_coefficient_update_freeze,
    .line_coefficient_clear, .line_offset_null_skip, .line_comfort_noise_disable,
    .line_residual_suppressor_disable, .line_step_speed_control_disable,
    .acou_estimate_subtract_skip, .acou_coefficient_update_freeze, .acou_coefficient_clear,
    .acou_offset_null_skip, .acou_comfort_noise_disable, .acou_residual_suppressor_disable,
    .acou_step_speed_control_disable, .acou_weighting_disable);
  ecc_host_model ecc_host_model_inst (.mclk, .sclk, .cs_n, .sdi, .sdo, .sdo_oe_n);

  // Control outputs gathered in register bit order
  assign mainv = {1'b0, recv_mute, send_mute, path_bypass, narrowband_detect_disable,
                  auto_gain_disable, howl_detect_disable, 1'b0};
  assign linev = {1'b0, line_step_speed_control_disable, line_residual_suppressor_disable,
                  line_comfort_noise_disable, line_offset_null_skip, line_coefficient_clear,
                  line_coefficient_update_freeze, line_estimate_subtract_skip};
  assign acouv = {acou_weighting_disable, acou_step_speed_control_disable,
                  acou_residual_suppressor_disable, acou_comfort_noise_disable,
                  acou_offset_null_skip, acou_coefficient_clear,
                  acou_coefficient_update_freeze, acou_estimate_subtract_skip};

  // ****************************************************
  // Clock, busy monitor and hang limit
  // ****************************************************
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Busy is too short to poll serially, so it is caught here
  always @(posedge mclk) begin
    if (init_busy === 1'b1) seen_busy <= 1'b1;
    cycles <= cycles + 1;
    // Ceiling about three times the expected run of some 10500 cycles
    if (cycles == 30000) begin
      fail_count++;
      $display("Error %0t: cycle limit reached", $time);
      stop_test();
    end
  end

  // ****************************************************
  // Compare and access tasks
  // ****************************************************
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: sample %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    ecc_host_model_inst.xfer({1'b0, a}, d, 16, rd);
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
    ecc_host_model_inst.xfer({1'b1, a}, 8'h00, 16, rd);
    chk8(rd, exp);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic t_reset();
    rdchk(7'h00, 8'h00);
    rdchk(7'h01, 8'h00);
    rdchk(7'h21, 8'h00);
    chk8(mainv | linev | acouv, 8'h00);
    $display("reset values done");
  endtask
  task automatic t_main();
    for (int b = 1; b < 8; b++) begin
      wr(7'h00, 8'h01 << b);
      chk8(mainv, (8'h01 << b) & 8'h7E);
      rdchk(7'h00, 8'h01 << b);
    end
    chk8({7'h00, linear_two_bit_shift}, 8'h00);
    $display("main control done");
  endtask
  task automatic t_canc();
    for (int b = 0; b < 8; b++) begin
      wr(7'h01, 8'h01 << b);
      wr(7'h21, 8'h01 << b);
      chk8(linev, (8'h01 << b) & 8'h7F);
      chk8(acouv, 8'h01 << b);
      rdchk(7'h01, 8'h01 << b);
      rdchk(7'h21, 8'h01 << b);
    end
    $display("canceller control done");
  endtask
  task automatic t_shift();
    wr(7'h00, 8'h80);
    wr(7'h01, 8'h80);
    repeat (2) @(posedge mclk);
    #1;
    chk8({7'h00, linear_two_bit_shift}, 8'h01);
    chk16(send_in_sh, 16'hE001);
    chk16(recv_in_sh, 16'h1FFF);
    chk16(send_out, 16'h000C);
    chk16(recv_out, 16'hFFFC);
    // Enable low freezes the sample stage although its input moves
    @(posedge mclk) {ce, send_in} <= {1'b0, 16'h0004};
    repeat (2) @(posedge mclk);
    #1;
    chk16(send_in_sh, 16'hE001);
    @(posedge mclk) {ce, send_in, recv_linear16} <= {1'b1, 16'h8004, 1'b0};
    repeat (2) @(posedge mclk);
    #1;
    chk8({7'h00, linear_two_bit_shift}, 8'h00);
    chk16(send_in_sh, 16'h8004);
    chk16(recv_out, 16'h3FFF);
    @(posedge mclk) {send_linear16, recv_linear16} <= 2'b01;
    repeat (2) @(posedge mclk);
    #1;
    chk8({7'h00, linear_two_bit_shift}, 8'h00);
    chk16(send_out, 16'h4003);
    @(posedge mclk) send_linear16 <= 1'b1;
    wr(7'h00, 8'h00);
    chk8({7'h00, linear_two_bit_shift}, 8'h00);
    $display("shift done");
  endtask
  task automatic t_init();
    wr(7'h01, 8'h5A);
    wr(7'h21, 8'h33);
    wr(7'h00, 8'h7E);
    @(posedge mclk) seen_busy <= 1'b0;
    wr(7'h00, 8'h01);
    chk8({7'h00, seen_busy}, 8'h01);
    ecc_host_model_inst.wait_init(ok);
    chk8({7'h00, ok}, 8'h01);
    rdchk(7'h01, 8'h00);
    rdchk(7'h21, 8'h00);
    chk8(mainv | linev | acouv, 8'h00);
    $display("initialization done");
  endtask
  task automatic t_odd();
    wr(7'h01, 8'h24);
    wr(7'h05, 8'hFF);
    rdchk(7'h05, 8'h00);
    ecc_host_model_inst.xfer(8'h01, 8'hFF, 12, rd);
    rdchk(7'h01, 8'h24);
    $display("unmapped and short frame done");
  endtask

  // Main sequence
  initial begin
    {rstn, seen_busy, fail_count, comparisons, cycles} = '0;
    ce = 1'b1;
    {send_linear16, recv_linear16} = 2'b11;
    {send_in, recv_in, send_proc, recv_proc} = {16'h8004, 16'h7FFC, 16'h4003, 16'h3FFF};
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    t_reset();
    t_main();
    t_canc();
    t_shift();
    t_init();
    t_odd();
    stop_test();
  end
endmodule // ecc_ctrl_regs_test
`default_nettype wire

// >>> verif/ecc_host_model.sv
// Host microcontroller model that drives the serial microport
`timescale 1ns/1ns
`default_nettype none
module ecc_host_model (
  // Clock
  input  wire logic mclk,
  // Microport pins
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe_n
);
  localparam int HALF = 4; // Sets a half period of 5 mclk (HALF + 1), a margin over the 3-cycle minimum

  // Idle pins: deselected, sclk parked low
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end

  // ****************************************************
  // One frame; fewer than 16 bits makes a short frame
  // ****************************************************
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, input int nbits,
                      output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    rd = 8'h00;
    @(posedge mclk) cs_n <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      @(posedge mclk) sdi <= sh[15-i];
      repeat (HALF - 1) @(posedge mclk);
      // Sample read data before the rise, unknown if not driven
      @(posedge mclk) begin
        if (i > 7) rd = {rd[6:0], (sdo_oe_n === 1'b0) ? sdo : 1'bx};
        sclk <= 1'b1;
      end
      repeat (HALF) @(posedge mclk);
      @(posedge mclk) sclk <= 1'b0;
    end
    // Released line shows the inverse so a stale bit is never trusted
    @(posedge mclk) begin
      cs_n <= 1'b1;
      sdi  <= ~sdi;
    end
    repeat (2) @(posedge mclk);
  endtask

  // Poll main control until initialization is done, bounded
  task automatic wait_init(output logic ok);
    logic [7:0] rd;
    ok = 1'b0;
    for (int n = 0; n < 8 && !ok; n++) begin
      xfer(8'h80, 8'h00, 16, rd);
      ok = (rd[0] === 1'b0);
    end
  endtask
endmodule // ecc_host_model
`default_nettype wire
